//--- pswc_defines.svh
// Purpose: Shared constants for the power-save and watchdog control block
// Assumes: SFR addresses are 8-bit, data 8-bit
// Notes: Bit positions index the power control, reload and enable registers
`ifndef PSWC_DEFINES_SVH
`define PSWC_DEFINES_SVH
`define PSWC_POWER_CONTROL_REG_ADDR 8'h87
`define PSWC_RELOAD_ADDR 8'h86
`define PSWC_IEN0_ADDR 8'ha8
`define PSWC_IEN1_ADDR 8'hb8
`define PSWC_B_IDLE_ARM 0
`define PSWC_B_PD_ARM 1
`define PSWC_B_GF0 2
`define PSWC_B_GF1 3
`define PSWC_B_SD 4
`define PSWC_B_NAP 5
`define PSWC_B_PD_START 6
`define PSWC_B_POWER_CONTROL_REG_TOP 7
`define PSWC_B_GUARD 6
`define PSWC_B_PRESCALE 7
`define PSWC_POWER_CONTROL_REG_KEEP 8'h9c
`define PSWC_POWER_CONTROL_REG_RESET 8'h00
`define PSWC_RELOAD_RESET 8'h00
`define PSWC_CYC_DIV 12
`define PSWC_SLOW_FACTOR 8
`define PSWC_EXPIRE_STATE 15'h7ffc
`define PSWC_RST_SHORT_LAST 8'h07
`define PSWC_RST_LONG_LAST 8'h7f
`define PSWC_ARM_LAST_AGE 2'h1
`define PSWC_PRE_LONG_LAST 5'h1f
`endif

//--- pswc_pkg.sv
// Purpose: Types of the power-save and watchdog control block
// Assumes: pswc_defines.svh is on the include path
// Notes: One state struct per module
`include "pswc_defines.svh"
package pswc_pkg;
  typedef enum logic [2:0] {
    PSWC_RUN = 3'h1,
    PSWC_NAP = 3'h2,
    PSWC_DOWN = 3'h4
  } pswc_mode_t;
  typedef struct packed {
    pswc_mode_t mode;
    logic [7:0] power_control_reg;
    logic [7:0] reload;
    logic idle_armed, idle_seen, pd_armed, pd_seen;
    logic refresh_arm;
    logic [1:0] refresh_age;
    logic guard_on, strap_done, strap_mode;
    logic slow_s1, slow_on;
    logic wdt_rst;
    logic [7:0] wdt_left;
    logic guard_load;
    logic [7:0] rdata;
    logic cpu_halt, osc_stop, strobe_low, strobe_high, alt_freeze, clk_out;
  } pswc_top_t;
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
    logic level;
  } pswc_div_t;
  typedef struct packed {
    logic [4:0] pre;
    logic [14:0] count;
    logic expire;
  } pswc_guard_t;
endpackage

//--- pswc_cycle_divider.sv
// Purpose: Machine cycle tick and clock output level from the oscillator
// Assumes: clk is the oscillator; stop freezes all activity
// Notes: Slow selects an eight times longer machine cycle
`timescale 1ns/1ps
`default_nettype none
module pswc_cycle_divider import pswc_pkg::*; #(
  parameter int CYC_DIV = `PSWC_CYC_DIV,
  parameter int SLOW_FACTOR = `PSWC_SLOW_FACTOR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic stop,
  output logic tick,
  output logic level
);
  localparam logic [6:0] FAST_LAST = 7'(CYC_DIV - 1);
  localparam logic [6:0] SLOW_LAST = 7'(CYC_DIV * SLOW_FACTOR - 1);
  if (CYC_DIV < 2 || CYC_DIV * SLOW_FACTOR > 128) begin : g_bad_div
    $error("pswc_cycle_divider: divide ratio out of range");
  end
  pswc_div_t st_reg, st_next;
  // Half of a period, for the clock output duty
  function automatic logic [6:0] half_of(input logic [6:0] last);
    half_of = 7'((32'(last) + 1) / 2);
  endfunction
  // Count one machine cycle, stop holds the level low
  always_comb begin
    logic [6:0] last;
    last = slow ? SLOW_LAST : FAST_LAST;
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (stop) begin
      st_next.level = 1'b0;
    end else begin
      if (st_reg.cnt >= last) begin
        st_next.cnt = '0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 7'h01;
      end
      st_next.level = st_next.cnt < half_of(last);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick = st_reg.tick;
  assign level = st_reg.level;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_tick_single;
    tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick wider than one cycle");
  property p_stop_quiet;
    stop |=> !tick && !level;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("divider active while stopped");
endmodule
`default_nettype wire

//--- pswc_guard_timer.sv
// Purpose: 15-bit watchdog counter with two ratio prescaler
// Assumes: tick is one machine cycle pulse
// Notes: Load wins over counting and hold; hold otherwise freezes count and prescaler
`timescale 1ns/1ps
`default_nettype none
module pswc_guard_timer import pswc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire logic hold,
  input wire logic load,
  input wire logic [6:0] reload,
  input wire logic prescale16,
  output logic [14:0] count,
  output logic expire
);
  pswc_guard_t st_reg, st_next;
  // Divide by two, or by thirty-two with the prescaler
  always_comb begin
    logic step;
    step = 1'b0;
    st_next = st_reg;
    st_next.expire = 1'b0;
    if (load) begin
      st_next.count = {reload, 8'h00};
      st_next.pre = '0;
    end else if (run && !hold && tick) begin
      step = prescale16 ? (st_reg.pre == `PSWC_PRE_LONG_LAST) : st_reg.pre[0];
      st_next.pre = step ? 5'h00 : st_reg.pre + 5'h01;
      if (step) begin
        st_next.count = st_reg.count + 15'h0001;
        st_next.expire = st_next.count == `PSWC_EXPIRE_STATE;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign count = st_reg.count;
  assign expire = st_reg.expire;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_hold_freeze;
    hold && !load |=> $stable(count);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("count moved while held");
  property p_load_value;
    load |=> count == {$past(reload), 8'h00};
  endproperty
  a_load_value: assert property (p_load_value) else $error("bad reload");
  property p_expire_state;
    expire |-> count == `PSWC_EXPIRE_STATE;
  endproperty
  a_expire_state: assert property (p_expire_state) else $error("expire off state");
endmodule
`default_nettype wire

//--- pswc_top.sv
// Purpose: Idle, power-down, slow-down and watchdog control of the core
// Assumes: SFR strobes and instr_end are synchronous one-cycle pulses
// Notes: rst is the external hardware reset; watchdog reset is an output
`timescale 1ns/1ps
`default_nettype none
module pswc_top import pswc_pkg::*; #(
  parameter int CYC_DIV = `PSWC_CYC_DIV,
  parameter int SLOW_FACTOR = `PSWC_SLOW_FACTOR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_save_enable_pin,
  input wire logic irq_wake,
  input wire logic instr_end,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic cpu_halt,
  output logic osc_stop,
  output logic strobes_low,
  output logic strobes_high,
  output logic alt_out_freeze,
  output logic clock_output_pin,
  output logic slow_active,
  output logic machine_tick,
  output logic guard_running,
  output logic guard_reset
);
  pswc_top_t st_reg, st_next;
  logic mc_tick;
  logic div_level;
  logic guard_expire;
  logic [14:0] guard_count;

  // Machine cycle source, slowed or stopped by the power modes
  pswc_cycle_divider #(
    .CYC_DIV(CYC_DIV),
    .SLOW_FACTOR(SLOW_FACTOR)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .slow(st_reg.slow_on),
    .stop(st_reg.mode == PSWC_DOWN),
    .tick(mc_tick),
    .level(div_level)
  );

  // Watchdog counter, frozen outside normal operation
  pswc_guard_timer u_guard (
    .clk(clk),
    .rst(rst),
    .tick(mc_tick),
    .run(st_reg.guard_on),
    .hold(st_reg.mode != PSWC_RUN),
    .load(st_reg.guard_load),
    .reload(st_reg.reload[6:0]),
    .prescale16(st_reg.reload[`PSWC_B_PRESCALE]),
    .count(guard_count),
    .expire(guard_expire)
  );

  // Address match on the SFR port
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
    hit = addr == want;
  endfunction

  // Arm flag ages on instruction ends, lives through the next instruction
  function automatic logic [1:0] age_arm(input logic armed, input logic seen,
                                         input logic step);
    age_arm = {armed, seen};
    if (armed && step) begin
      age_arm = seen ? 2'h0 : 2'h3;
    end
  endfunction

  // Next state of the whole controller
  always_comb begin
    logic power_control_reg_wr;
    logic power_ok;
    logic nap_req;
    logic pd_req;
    logic [1:0] aged;
    power_control_reg_wr = sfr_wr && hit(sfr_addr, `PSWC_POWER_CONTROL_REG_ADDR);
    st_next = st_reg;
    st_next.guard_load = 1'b0;
    power_ok = !power_save_enable_pin && !st_reg.strap_mode;
    aged = age_arm(st_reg.idle_armed, st_reg.idle_seen, instr_end);
    st_next.idle_armed = aged[1];
    st_next.idle_seen = aged[0];
    aged = age_arm(st_reg.pd_armed, st_reg.pd_seen, instr_end);
    st_next.pd_armed = aged[1];
    st_next.pd_seen = aged[0];
    nap_req = power_control_reg_wr && sfr_wdata[`PSWC_B_NAP] && !sfr_wdata[`PSWC_B_IDLE_ARM]
      && st_reg.idle_armed;
    pd_req = power_control_reg_wr && sfr_wdata[`PSWC_B_PD_START] && !sfr_wdata[`PSWC_B_PD_ARM]
      && st_reg.pd_armed;
    if (power_control_reg_wr) begin
      st_next.power_control_reg = sfr_wdata & `PSWC_POWER_CONTROL_REG_KEEP;
      st_next.idle_armed = sfr_wdata[`PSWC_B_IDLE_ARM] && !sfr_wdata[`PSWC_B_NAP];
      st_next.idle_seen = 1'b0;
      st_next.pd_armed = sfr_wdata[`PSWC_B_PD_ARM] && !sfr_wdata[`PSWC_B_PD_START];
      st_next.pd_seen = 1'b0;
    end
    if (sfr_wr && hit(sfr_addr, `PSWC_RELOAD_ADDR)) begin
      st_next.reload = sfr_wdata;
    end
    // Mode machine
    unique case (st_reg.mode)
      PSWC_RUN: begin
        if (power_ok && pd_req) begin
          st_next.mode = PSWC_DOWN;
        end else if (power_ok && nap_req) begin
          st_next.mode = PSWC_NAP;
        end
      end
      PSWC_NAP: begin
        if (irq_wake) begin
          st_next.mode = PSWC_RUN;
        end
      end
      PSWC_DOWN: begin
        st_next.mode = PSWC_DOWN;
      end
      default: begin
        st_next.mode = PSWC_RUN;
      end
    endcase
    if (mc_tick) begin
      st_next.slow_s1 = st_reg.power_control_reg[`PSWC_B_SD] && power_ok;
      st_next.slow_on = st_reg.slow_s1;
    end
    if (mc_tick && st_reg.refresh_arm) begin
      if (st_reg.refresh_age == `PSWC_ARM_LAST_AGE) begin
        st_next.refresh_arm = 1'b0;
      end else begin
        st_next.refresh_age = st_reg.refresh_age + 2'h1;
      end
    end
    if (sfr_wr && hit(sfr_addr, `PSWC_IEN0_ADDR) && sfr_wdata[`PSWC_B_GUARD]) begin
      st_next.refresh_arm = 1'b1;
      st_next.refresh_age = 2'h0;
    end
    if (sfr_wr && hit(sfr_addr, `PSWC_IEN1_ADDR) && sfr_wdata[`PSWC_B_GUARD]) begin
      if (!st_reg.guard_on || st_reg.refresh_arm) begin
        st_next.guard_load = 1'b1;
      end
      st_next.guard_on = 1'b1;
      st_next.refresh_arm = 1'b0;
    end
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.strap_mode = power_save_enable_pin;
      if (power_save_enable_pin) begin
        st_next.guard_on = 1'b1;
        st_next.guard_load = 1'b1;
      end
    end
    if (guard_expire && !st_reg.wdt_rst) begin
      st_next.wdt_rst = 1'b1;
      st_next.wdt_left = st_reg.reload[`PSWC_B_PRESCALE] ? `PSWC_RST_LONG_LAST
        : `PSWC_RST_SHORT_LAST;
    end else if (st_reg.wdt_rst && mc_tick) begin
      if (st_reg.wdt_left == 8'h00) begin
        st_next.wdt_rst = 1'b0;
        st_next.guard_load = 1'b1;
      end else begin
        st_next.wdt_left = st_reg.wdt_left - 8'h01;
      end
    end
    // Internal reset reinitialises the power control register but keeps the reload value and the watchdog running
    if (st_next.wdt_rst) begin
      st_next.mode = PSWC_RUN;
      st_next.power_control_reg = `PSWC_POWER_CONTROL_REG_RESET;
      st_next.idle_armed = 1'b0;
      st_next.pd_armed = 1'b0;
      st_next.refresh_arm = 1'b0;
      st_next.slow_s1 = 1'b0;
      st_next.slow_on = 1'b0;
    end
    // Read data, arm and start bits always zero
    if (sfr_rd) begin
      st_next.rdata = 8'h00;
      if (hit(sfr_addr, `PSWC_POWER_CONTROL_REG_ADDR)) begin
        st_next.rdata = st_reg.power_control_reg & `PSWC_POWER_CONTROL_REG_KEEP;
      end else if (hit(sfr_addr, `PSWC_RELOAD_ADDR)) begin
        st_next.rdata = st_reg.reload;
      end else if (hit(sfr_addr, `PSWC_IEN0_ADDR)) begin
        st_next.rdata[`PSWC_B_GUARD] = st_reg.refresh_arm;
      end else if (hit(sfr_addr, `PSWC_IEN1_ADDR)) begin
        st_next.rdata[`PSWC_B_GUARD] = st_reg.guard_on;
      end
    end
    st_next.cpu_halt = st_next.mode != PSWC_RUN;
    st_next.osc_stop = st_next.mode == PSWC_DOWN;
    st_next.strobe_low = st_next.mode == PSWC_DOWN;
    st_next.strobe_high = st_next.mode == PSWC_NAP;
    st_next.alt_freeze = st_next.mode == PSWC_DOWN;
    st_next.clk_out = div_level && st_next.mode != PSWC_DOWN;
  end

  // State register; external reset clears all fields and sets the mode to RUN
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mode <= PSWC_RUN;
      st_reg.power_control_reg <= `PSWC_POWER_CONTROL_REG_RESET;
      st_reg.reload <= `PSWC_RELOAD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata = st_reg.rdata;
  assign cpu_halt = st_reg.cpu_halt;
  assign osc_stop = st_reg.osc_stop;
  assign strobes_low = st_reg.strobe_low;
  assign strobes_high = st_reg.strobe_high;
  assign alt_out_freeze = st_reg.alt_freeze;
  assign clock_output_pin = st_reg.clk_out;
  assign slow_active = st_reg.slow_on;
  assign machine_tick = mc_tick;
  assign guard_running = st_reg.guard_on;
  assign guard_reset = st_reg.wdt_rst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic pd_try;
  assign pd_try = sfr_wr && hit(sfr_addr, `PSWC_POWER_CONTROL_REG_ADDR)
    && sfr_wdata[`PSWC_B_PD_START] && !sfr_wdata[`PSWC_B_PD_ARM];
  property p_pd_enter;
    pd_try && st_reg.pd_armed && st_reg.mode == PSWC_RUN && !power_save_enable_pin
      && !st_reg.strap_mode && !guard_expire && !st_reg.wdt_rst |=> osc_stop && strobes_low;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
  property p_pd_both;
    sfr_wr && hit(sfr_addr, `PSWC_POWER_CONTROL_REG_ADDR) && sfr_wdata[`PSWC_B_PD_ARM]
      && sfr_wdata[`PSWC_B_PD_START] && st_reg.mode == PSWC_RUN |=> !osc_stop;
  endproperty
  a_pd_both: assert property (p_pd_both) else $error("concurrent bits entered power-down");
  property p_pd_pins;
    st_reg.mode == PSWC_DOWN |-> strobes_low && !strobes_high && !clock_output_pin
      && alt_out_freeze;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("pins wrong in power-down");
  property p_pd_stays;
    osc_stop |=> osc_stop;
  endproperty
  a_pd_stays: assert property (p_pd_stays) else $error("power-down left without reset");
  property p_read_zero;
    sfr_rd && hit(sfr_addr, `PSWC_POWER_CONTROL_REG_ADDR) |=> sfr_rdata[1:0] == 2'h0
      && sfr_rdata[6:5] == 2'h0;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("arm or start bit read one");
  property p_strap_block;
    st_reg.strap_mode |-> !cpu_halt && !slow_active;
  endproperty
  a_strap_block: assert property (p_strap_block) else $error("power mode with strap set");
  property p_nap_wake;
    st_reg.mode == PSWC_NAP && irq_wake |=> !cpu_halt;
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("idle not left on interrupt");
  property p_arm_clear;
    $rose(st_reg.refresh_arm) |-> ##[1:300] !st_reg.refresh_arm;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("refresh arm stuck");
  property p_guard_sticky;
    guard_running |=> guard_running;
  endproperty
  a_guard_sticky: assert property (p_guard_sticky) else $error("watchdog stopped");
  property p_rst_len;
    $rose(guard_reset) |-> guard_reset [*8];
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("watchdog reset too short");
  property p_slow_in;
    $rose(st_reg.power_control_reg[`PSWC_B_SD]) && !power_save_enable_pin && !st_reg.strap_mode
      && !st_reg.slow_on && !guard_reset |-> ##[1:200] (slow_active || guard_reset
      || power_save_enable_pin || !st_reg.power_control_reg[`PSWC_B_SD]);
  endproperty
  a_slow_in: assert property (p_slow_in) else $error("slow-down late");
  c_pd: cover property (st_reg.mode == PSWC_RUN ##1 st_reg.mode == PSWC_DOWN);
  c_nap: cover property (st_reg.mode == PSWC_NAP ##1 st_reg.mode == PSWC_RUN);
  c_wdt: cover property ($rose(guard_reset));
  c_slow_nap: cover property (slow_active && st_reg.mode == PSWC_NAP);
endmodule
`default_nettype wire

//--- test_power_save_and_watchdog_control.sv
// Purpose: Self-checking bench for the power-save and watchdog control block
// Assumes: pswc_top with its default machine cycle of 12 clocks
// Notes: Bench model keeps stored control bits and watchdog timing in integers
`timescale 1ns/1ps
`default_nettype none
`include "pswc_defines.svh"
module test_power_save_and_watchdog_control import pswc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic save_pin = 1'b0;
  logic irq_wake = 1'b0;
  logic instr_end = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic cpu_halt, osc_stop, strobes_low, strobes_high, alt_out_freeze;
  logic clock_output_pin, slow_active, machine_tick, guard_running, guard_reset;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n, t, e;
  logic [7:0] rv, power_control_reg_m, reload_m, d;

  pswc_top DUT (
    .clk(clk), .rst(rst), .power_save_enable_pin(save_pin), .irq_wake(irq_wake),
    .instr_end(instr_end), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_halt(cpu_halt),
    .osc_stop(osc_stop), .strobes_low(strobes_low), .strobes_high(strobes_high),
    .alt_out_freeze(alt_out_freeze), .clock_output_pin(clock_output_pin),
    .slow_active(slow_active), .machine_tick(machine_tick),
    .guard_running(guard_running), .guard_reset(guard_reset)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Cycle count and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 45000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Passes the expected value through when within tolerance
  function automatic int near(input int v, input int ex, input int tol);
    return (v >= ex - tol && v <= ex + tol) ? ex : v;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk);
    #2;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = dv;
    @(posedge clk);
    #2;
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge clk);
    #2;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk);
    #2;
    sfr_rd = 1'b0;
    dv = sfr_rdata;
  endtask

  // Power control write with model update
  task automatic pw(input logic [7:0] dv);
    wr(`PSWC_POWER_CONTROL_REG_ADDR, dv);
    power_control_reg_m = dv & 8'h9c;
  endtask

  task automatic iep();
    @(posedge clk);
    #2;
    instr_end = 1'b1;
    @(posedge clk);
    #2;
    instr_end = 1'b0;
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      while (machine_tick !== 1'b1) @(posedge clk);
    end
    #2;
  endtask

  task automatic rst_seq(input logic p);
    save_pin = p;
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(2);
    power_control_reg_m = 8'h00;
    reload_m = 8'h00;
  endtask

  // Machine ticks until watchdog reset, bounded
  task automatic wait_exp(output int cnt);
    cnt = 0;
    while (guard_reset !== 1'b1 && cnt < 2000) begin
      @(posedge clk);
      if (machine_tick === 1'b1) cnt++;
    end
  endtask

  initial begin
    void'($urandom(32'h8fbe));
    rst_seq(1'b0);
    rd(`PSWC_POWER_CONTROL_REG_ADDR, rv); chk(rv, 8'h00);
    rd(`PSWC_RELOAD_ADDR, rv); chk(rv, 8'h00);
    rd(8'h55, rv); chk(rv, 8'h00);
    // Random flags; arm and start always paired so neither idle nor power-down enters
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      d[6] = d[1];
      d[5] = d[0];
      pw(d);
      rd(`PSWC_POWER_CONTROL_REG_ADDR, rv); chk(rv, power_control_reg_m);
      chk({cpu_halt, osc_stop}, 2'b00);
    end
    pw(8'h00);
    ticks(3);
    // Slow-down entry, tick spacing, exit
    pw(8'h10);
    ticks(2); chk(slow_active, 1'b1);
    ticks(1);
    t = cycles;
    ticks(1); chk(cycles - t, 12 * 8);
    pw(8'h00);
    ticks(2); chk(slow_active, 1'b0);
    ticks(1);
    t = cycles;
    ticks(1); chk(cycles - t, 12);
    // Idle entry and wake by interrupt
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h01);
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h20);
    cyc(1); chk({cpu_halt, strobes_high, osc_stop}, 3'b110);
    irq_wake = 1'b1;
    cyc(2);
    irq_wake = 1'b0;
    chk({cpu_halt, strobes_high}, 2'b00);
    // Arm expired after two instruction ends
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h01);
    iep();
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h20);
    cyc(1); chk(cpu_halt, 1'b0);
    // Hardware reset ends idle
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h01);
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h20);
    cyc(1); chk(cpu_halt, 1'b1);
    rst_seq(1'b0); chk({cpu_halt, strobes_high}, 2'b00);
    // Pin high blocks power-down; rising pin never starts watchdog
    save_pin = 1'b1;
    cyc(3); chk(guard_running, 1'b0);
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h02);
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h40);
    cyc(1); chk(osc_stop, 1'b0);
    save_pin = 1'b0;
    cyc(2);
    // Idle and power-down requested together
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h03);
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h60);
    cyc(1);
    chk({osc_stop, strobes_low, alt_out_freeze, cpu_halt, strobes_high}, 5'b11110);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (machine_tick === 1'b1) n++;
    end
    #2;
    chk(n, 0);
    chk(clock_output_pin, 1'b0);
    irq_wake = 1'b1;
    cyc(3); chk({osc_stop, strobes_low}, 2'b11);
    irq_wake = 1'b0;
    rst_seq(1'b0); chk({osc_stop, cpu_halt, strobes_low}, 3'b000);
    // Software start from short reload value
    pw(8'h0c);
    reload_m = 8'h7f;
    wr(`PSWC_RELOAD_ADDR, reload_m);
    rd(`PSWC_RELOAD_ADDR, rv); chk(rv, reload_m);
    wr(`PSWC_IEN1_ADDR, 8'h40);
    cyc(1); chk(guard_running, 1'b1);
    e = (32'h7ffc - {reload_m[6:0], 8'h00}) * 2;
    // Stale arm: refresh must not happen
    ticks(100);
    wr(`PSWC_IEN0_ADDR, 8'h40);
    ticks(3);
    wr(`PSWC_IEN1_ADDR, 8'h40);
    wait_exp(n); chk(near(n + 103, e, 3), e);
    n = 0;
    while (guard_reset === 1'b1) begin
      @(posedge clk);
      if (machine_tick === 1'b1) n++;
    end
    #2;
    chk(near(n, 8, 1), 8);
    chk(guard_running, 1'b1);
    rd(`PSWC_POWER_CONTROL_REG_ADDR, rv); chk(rv, 8'h00);
    rd(`PSWC_RELOAD_ADDR, rv); chk(rv, reload_m);
    // Proper refresh restarts the period
    ticks(200);
    wr(`PSWC_IEN0_ADDR, 8'h40);
    wr(`PSWC_IEN1_ADDR, 8'h40);
    wait_exp(n); chk(near(n, e, 3), e);
    cyc(200);
    rst_seq(1'b0); chk({guard_running, guard_reset}, 2'b00);
    // Strap start disables all power modes
    rst_seq(1'b1); chk(guard_running, 1'b1);
    save_pin = 1'b0;
    pw(8'h10);
    ticks(3); chk(slow_active, 1'b0);
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h02);
    iep();
    wr(`PSWC_POWER_CONTROL_REG_ADDR, 8'h40);
    cyc(1); chk({osc_stop, cpu_halt}, 2'b00);
    conclude();
  end
endmodule
`default_nettype wire
